// File: bench/test_uart_break_rx_wakeup.sv
// Purpose: Self-checking bench for break send and receiver
// Assumes: Divisor 2 and ratio 16 give 32 pclk per bit
// Notes:   Seeded random data and break formats
`timescale 1ns/1ps
module test_uart_break_rx_wakeup;
   localparam int          BIT_CLKS = 32;
   localparam logic [31:0] CTRL_ON  = 32'h001E0003;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_in;
   logic        tx_out;
   logic        tx_oe;
   logic [31:0] q;
   logic [31:0] cfg;
   logic [7:0]  d;
   logic        err;
   int          num_errors;
   int          samples_checked;
   int          cycles;
   int          n;

   uart_break_rx_wakeup DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe));
   uart_partner #(.BIT_CLKS(BIT_CLKS)) partner (.pclk(pclk), .tx_out(tx_out), .tx_oe(tx_oe),
      .rx_line(rx_in));

   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic close_out();
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Break length in pclk cycles for a control word
   function automatic logic [31:0] brk_len(input logic [31:0] c);
      logic [31:0] b;
      b = 32'hA + {31'h0, c[12]} + (c[13] ? 32'h3 : 32'h0);
      if (c[11])
         b = b + 32'h2;
      else if (c[10])
         b = b + 32'h1;
      return b * BIT_CLKS;
   endfunction

   // Bit order reversed, for msb-first reception
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = v[7 - i];
      return r;
   endfunction

   // Frame in, then the low four status flags
   task automatic rx_chk(input logic [7:0] v, input logic stop, input logic [31:0] st);
      partner.send(v, stop);
      apb(1'b0, 8'h08, 32'h0, q);
      chk("status", st, q & 32'hF);
   endtask

   // Hang guard
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         num_errors++;
         close_out();
      end
   end

   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      cycles = 0;
      void'($urandom(32'h220573b1));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0, q);
      chk("ctrl", 32'h001E0000, q);
      apb(1'b0, 8'h04, 32'h0, q);
      chk("baud", 32'h4, q);
      apb(1'b0, 8'h08, 32'h0, q);
      chk("status", 32'h20, q);
      apb(1'b0, 8'h14, 32'h0, q);
      chk("unmapped", 32'h1, {q[30:0], err});
      apb(1'b1, 8'h04, 32'h2, q);
      apb(1'b1, 8'h00, CTRL_ON, q);
      // Breaks: plain, random format, longest
      for (n = 0; n < 3; n++)
      begin
         cfg = (n == 0) ? 32'h0 : (n == 2) ? 32'h3800 : ($urandom & 32'h3C00);
         apb(1'b1, 8'h00, CTRL_ON | cfg | 32'h4, q);
         apb(1'b1, 8'h00, CTRL_ON | cfg, q);
         while (tx_out !== 1'b0) @(posedge pclk);
         apb(1'b1, 8'h00, (CTRL_ON | cfg) & ~32'h1, q);
         @(posedge pclk);
         chk("tx_oe", 32'h1, {31'h0, tx_oe});
         apb(1'b1, 8'h00, CTRL_ON | cfg, q);
         while (tx_out !== 1'b1) @(posedge pclk);
         repeat (2) @(posedge pclk);
         chk("break_len", brk_len(cfg), 32'(partner.low_len));
      end
      apb(1'b1, 8'h00, CTRL_ON, q);
      // Clean character, then overrun
      d = 8'($urandom);
      rx_chk(d, 1'b1, 32'h1);
      apb(1'b0, 8'h0C, 32'h0, q);
      chk("data", {24'h0, d}, q);
      partner.send(~d, 1'b1);
      rx_chk(d, 1'b1, 32'h3);
      apb(1'b0, 8'h0C, 32'h0, q);
      chk("data", {24'h0, ~d}, q);
      apb(1'b1, 8'h08, 32'h1E, q);
      // Low stop bit
      rx_chk(8'h55, 1'b0, 32'h9);
      apb(1'b0, 8'h0C, 32'h0, q);
      chk("data", 32'h55, q);
      apb(1'b1, 8'h08, 32'h1E, q);
      // Address-mark wakeup from sleep
      apb(1'b1, 8'h00, CTRL_ON | 32'h18, q);
      rx_chk(d & 8'h7F, 1'b1, 32'h0);
      rx_chk(d | 8'h80, 1'b1, 32'h1);
      apb(1'b0, 8'h00, 32'h0, q);
      chk("sleep", 32'h0, q & 32'h8);
      apb(1'b0, 8'h0C, 32'h0, q);
      chk("data", {24'h0, d | 8'h80}, q);
      // Idle-line wakeup: waking idle sets no idle flag, later idle does
      apb(1'b1, 8'h08, 32'h1E, q);
      apb(1'b1, 8'h00, CTRL_ON | 32'h8, q);
      rx_chk(d, 1'b1, 32'h0);
      repeat (12 * BIT_CLKS) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0, q);
      chk("sleep", 32'h0, q & 32'h8);
      apb(1'b0, 8'h08, 32'h0, q);
      chk("idle", 32'h0, q & 32'h10);
      rx_chk(~d, 1'b1, 32'h1);
      repeat (12 * BIT_CLKS) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0, q);
      chk("idle", 32'h11, q & 32'h1F);
      // Dual-edge sampling with msb-first order
      apb(1'b1, 8'h00, CTRL_ON | 32'h4100, q);
      apb(1'b0, 8'h0C, 32'h0, q);
      rx_chk(d, 1'b1, 32'h1);
      apb(1'b0, 8'h0C, 32'h0, q);
      chk("data", {24'h0, rev8(d)}, q);
      close_out();
   end
endmodule

// File: bench/uart_partner.sv
// Purpose: Remote serial station facing the port's pins
// Assumes: Bit time is a whole number of pclk cycles
// Notes:   Sends eight-bit frames and times low stretches on the line
`timescale 1ns/1ps
module uart_partner
#(
   parameter int BIT_CLKS = 32
)
(
   // Clock
   input  wire logic pclk,
   // Serial pins
   input  wire logic tx_out,
   input  wire logic tx_oe,
   output logic      rx_line
);
   logic        line;
   int unsigned low_run;
   int unsigned low_len;

   // Released pin is pulled up
   assign line = tx_oe ? tx_out : 1'b1;

   initial
   begin
      rx_line = 1'b1;
      low_run = 0;
      low_len = 0;
   end

   // Length of the latest low stretch, in pclk cycles
   always @(posedge pclk)
   begin
      if (line === 1'b0)
         low_run <= low_run + 1;
      else
      begin
         if (low_run != 0)
            low_len <= low_run;
         low_run <= 0;
      end
   end

   // Low start, eight data bits lsb first, stop at the given level
   task automatic send(input logic [7:0] d, input logic stop);
      int i;
      rx_line <= 1'b0;
      repeat (BIT_CLKS) @(posedge pclk);
      for (i = 0; i < 8; i++)
      begin
         rx_line <= d[i];
         repeat (BIT_CLKS) @(posedge pclk);
      end
      rx_line <= stop;
      repeat (BIT_CLKS) @(posedge pclk);
      rx_line <= 1'b1;
      repeat (2 * BIT_CLKS) @(posedge pclk);
   endtask
endmodule

// File: hw/uart_break_rx_wakeup.sv
// Purpose: Break/idle transmit and oversampled receiver with wakeup
// Assumes: pclk 20 MHz, rx_in synchronous to pclk
// Notes:   Registers over APB, zero-wait answer after setup
// Function
// R1 - Break drives output low for a whole character including start, stop
// R2 - Break length 10 plus data, stop and long-break extras, 10 to 16
// R3 - Break-send written one then zero queues one break
// R4 - Break-send still one when break loads queues another break
// R5 - Transmit enable cleared then set queues one idle character
// R6 - Output stays driven while enable briefly cleared mid character
// R7 - Receive input inverted on flip bit; receiver runs only when enabled
// R8 - Frame: low start, 8 to 10 data bits, one or two stops
// R9 - Character buffered and full set if empty, else overrun, discarded
// R10 - Sample 4x to 32x; zero after three ones is falling edge
// R11 - Start checked at OVERSAMPLING_RATIO/2..+2; two zeros accept; edge restarts count
// R12 - Three samples per bit, value by majority
// R13 - Any disagreeing sample sets noise when character is buffered
// R14 - Dual-edge: 2xOSR segments, samples at OVERSAMPLING_RATIO..OVERSAMPLING_RATIO+2
// R15 - Edge detector always runs and realigns bit counter unless disabled
// R16 - Framing error, not break, preloads three ones into edge history
// R17 - Sleep blocks receiver flags except idle when allowed
// R18 - Idle-line wakeup clears sleep after one character time of idle
// R19 - Waking idle sets no idle flag unless allow bit set
// R20 - Idle-type clear counts after start bit, set counts after stop
// R21 - Address-mark wakeup clears sleep on marked character, buffers it
// R22 - Match enables filter marked frames and following data frames
// R23 - Baud from 13-bit divider; transmitter at rate over OVERSAMPLING_RATIO
// R24 - Cleared idle flag rearms only after a buffered character
// R25 - Oversampling ratio from software field, frozen while receiving
`timescale 1ns/1ps
`include "uart_brk_map.svh"
module uart_break_rx_wakeup
   import uart_brk_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial pins
   input  wire logic        rx_in,
   output logic             tx_out,
   output logic             tx_oe
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [3:0] dbits_f(input ctrl_type c);
      dbits_f = `BASE_DBITS + (c.ten_bit_select ? 4'h2 : {3'h0, c.nine_bit_select});
   endfunction
   function automatic logic [4:0] cbits_f(input ctrl_type c);
      cbits_f = {1'b0, dbits_f(c)} + 5'h02 + {4'h0, c.two_stop_select};
   endfunction

   ctrl_type     ctrl_r;
   stat_type     st_r;
   logic [12:0]  baud_r;
   logic [15:0]  match_r;
   logic [9:0]   rxbuf_r;
   logic [31:0]  prdata_r;
   logic         pready_r;
   logic         pslverr_r;
   logic         sleep_clr;
   logic         wr_en;
   logic         rd_data;
   logic         mapped;

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign wr_en   = psel & penable & pready_r & pwrite;
   assign rd_data = psel & penable & pready_r & ~pwrite & (paddr == `OFS_DATA);
   assign mapped  = (paddr == `OFS_CTRL) | (paddr == `OFS_BAUD) | (paddr == `OFS_STATUS)
                  | (paddr == `OFS_DATA) | (paddr == `OFS_MATCH);

   // ----------------------------------------
   // APB answer: data latched in setup, ready in access
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else if (psel & ~penable)
      begin
         pready_r  <= 1'b1;
         pslverr_r <= ~mapped;
         case (paddr)
            `OFS_CTRL:   prdata_r <= {10'h000, ctrl_r};
            `OFS_BAUD:   prdata_r <= {19'h00000, baud_r};
            `OFS_STATUS: prdata_r <= {26'h0000000, st_r};
            `OFS_DATA:   prdata_r <= {22'h000000, rxbuf_r};
            `OFS_MATCH:  prdata_r <= {16'h0000, match_r};
            default:     prdata_r <= 32'h00000000;
         endcase
      end
      else
         pready_r <= 1'b0;

   // Control, divisor and match registers
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctrl_r  <= ctrl_type'(`RST_CTRL);
         baud_r  <= `RST_BAUD;
         match_r <= 16'h0000;
      end
      else
      begin
         if (sleep_clr)
            ctrl_r.rx_sleep <= 1'b0;        // [R18] [R21]
         if (wr_en && paddr == `OFS_CTRL)
         begin
            ctrl_r <= ctrl_type'(pwdata[21:0]);
            if (ctrl_r.rx_on)
               ctrl_r.osr_m1 <= ctrl_r.osr_m1;  // [R25]
         end
         if (wr_en && paddr == `OFS_BAUD)
            baud_r <= pwdata[12:0];
         if (wr_en && paddr == `OFS_MATCH)
            match_r <= pwdata[15:0];
      end

   // ----------------------------------------
   // Baud generator: rise and mid ticks
   // ----------------------------------------
   logic [12:0] brc_r;
   logic        rise;
   logic        fall;
   logic [5:0]  oversampling_ratio;
   logic [6:0]  nseg;
   logic [6:0]  sp;
   logic        stk;

   assign rise = (brc_r == 13'h0000) & (baud_r != 13'h0000);
   assign fall = (brc_r == {1'b0, baud_r[12:1]}) & (baud_r > 13'h0001);
   assign oversampling_ratio  = {1'b0, ctrl_r.osr_m1} + 6'h01;
   assign nseg = ctrl_r.dual_edge_sample ? {oversampling_ratio, 1'b0} : {1'b0, oversampling_ratio};  // [R14]
   assign sp   = ctrl_r.dual_edge_sample ? {1'b0, oversampling_ratio} : {2'h0, oversampling_ratio[5:1]};
   assign stk  = rise | (ctrl_r.dual_edge_sample & fall);

   // Modulus divider [R23]
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         brc_r <= 13'h0000;
      else if (brc_r >= baud_r - 13'h0001)
         brc_r <= 13'h0000;
      else
         brc_r <= brc_r + 13'h0001;

   // ----------------------------------------
   // Transmitter: break and idle characters
   // ----------------------------------------
   logic [4:0] txseg_r;
   logic [4:0] txcnt_r;
   logic       txbrk_r;
   logic       brk_q_r;
   logic       idle_q_r;
   logic       bs_prev_r;
   logic       ton_prev_r;
   logic       tx_tick;
   logic       tx_free;
   logic [4:0] brk_len;
   logic       tx_out_r;
   logic       tx_oe_r;

   assign tx_tick = rise & (txseg_r == ctrl_r.osr_m1);    // [R23]
   assign tx_free = (txcnt_r <= 5'h01);
   assign brk_len = cbits_f(ctrl_r) + (ctrl_r.long_break_select ? `LONG_EXTRA : 5'h00);  // [R2]
   assign tx_out  = tx_out_r;
   assign tx_oe   = tx_oe_r;

   // Bit-time prescaler
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         txseg_r <= 5'h00;
      else if (rise)
         txseg_r <= tx_tick ? 5'h00 : txseg_r + 5'h01;

   // Queues and shifter count
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         txcnt_r    <= 5'h00;
         txbrk_r    <= 1'b0;
         brk_q_r    <= 1'b0;
         idle_q_r   <= 1'b0;
         bs_prev_r  <= 1'b0;
         ton_prev_r <= 1'b0;
      end
      else
      begin
         bs_prev_r  <= ctrl_r.break_send;
         ton_prev_r <= ctrl_r.tx_on;
         if (tx_tick)
         begin
            if (txcnt_r != 5'h00)
               txcnt_r <= txcnt_r - 5'h01;
            if (tx_free && brk_q_r)
            begin
               txcnt_r <= brk_len;
               txbrk_r <= 1'b1;
               brk_q_r <= ctrl_r.break_send;    // [R4]
            end
            else if (tx_free && idle_q_r)
            begin
               txcnt_r  <= cbits_f(ctrl_r);
               txbrk_r  <= 1'b0;
               idle_q_r <= 1'b0;
            end
         end
         if (bs_prev_r & ~ctrl_r.break_send)
            brk_q_r <= 1'b1;                     // [R3]
         if (~ton_prev_r & ctrl_r.tx_on)
            idle_q_r <= 1'b1;                    // [R5]
      end

   // Pin level and drive
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_out_r <= 1'b1;
         tx_oe_r  <= 1'b0;
      end
      else
      begin
         tx_out_r <= ~(txbrk_r & (txcnt_r != 5'h00));   // [R1]
         tx_oe_r  <= ctrl_r.tx_on | (txcnt_r != 5'h00); // [R6]
      end

   // ----------------------------------------
   // Receiver sampling
   // ----------------------------------------
   rx_state_type rst_r;
   logic [2:0]   hist_r;
   logic [6:0]   seg_r;
   logic [6:0]   seg_nxt;
   logic [1:0]   vs_r;
   logic [3:0]   bit_r;
   logic [9:0]   rxsh_r;
   logic         noise_r;
   logic         fe_r;
   logic         zero_r;
   logic         s;
   logic         fedge;
   logic         decide;
   logic         maj;
   logic         same;
   logic [3:0]   db;
   logic         done;
   logic         fe_now;
   logic         brk_now;

   assign s       = rx_in ^ ctrl_r.rx_polarity_flip;          // [R7]
   assign fedge   = (hist_r == 3'b111) & ~s;                  // [R10]
   assign seg_nxt = (seg_r >= nseg) ? 7'h01 : seg_r + 7'h01;
   assign decide  = (seg_r == sp + 7'h02);
   assign maj     = (vs_r[0] & vs_r[1]) | (vs_r[0] & s) | (vs_r[1] & s);  // [R12]
   assign same    = (vs_r[0] == s) & (vs_r[1] == s);
   assign db      = dbits_f(ctrl_r);
   assign done    = ctrl_r.rx_on & stk & (rst_r == S_FRAME) & decide
                  & (bit_r == db + 4'h1 + {3'h0, ctrl_r.two_stop_select});  // [R8]
   assign fe_now  = fe_r | ~maj;
   assign brk_now = zero_r & ~maj;

   // Edge history, runs whenever enabled
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         hist_r <= 3'b000;
      else if (!ctrl_r.rx_on)
         hist_r <= 3'b000;
      else if (done && fe_now && !brk_now)
         hist_r <= 3'b111;                     // [R16]
      else if (stk)
         hist_r <= {hist_r[1:0], s};           // [R15]

   // Start check and frame sampling
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rst_r   <= S_HUNT;
         seg_r   <= 7'h00;
         vs_r    <= 2'b00;
         bit_r   <= 4'h0;
         rxsh_r  <= 10'h000;
         noise_r <= 1'b0;
         fe_r    <= 1'b0;
         zero_r  <= 1'b0;
      end
      else if (!ctrl_r.rx_on)
         rst_r <= S_HUNT;                       // [R7]
      else if (stk)
      begin
         if (seg_r == sp)
            vs_r[0] <= s;
         if (seg_r == sp + 7'h01)
            vs_r[1] <= s;
         case (rst_r)
            S_HUNT:
               if (fedge)
               begin
                  seg_r <= 7'h01;               // [R10]
                  rst_r <= S_START;
               end
            S_START:
               if (fedge)
                  seg_r <= 7'h01;               // [R11]
               else
               begin
                  seg_r <= seg_nxt;
                  if (decide)
                  begin
                     rst_r   <= maj ? S_HUNT : S_FRAME;  // [R11]
                     bit_r   <= 4'h1;
                     rxsh_r  <= 10'h000;
                     noise_r <= ~same;
                     fe_r    <= 1'b0;
                     zero_r  <= 1'b1;
                  end
               end
            S_FRAME:
            begin
               seg_r <= (fedge && !ctrl_r.edge_realign_off) ? 7'h01 : seg_nxt;  // [R15]
               if (decide)
               begin
                  bit_r   <= bit_r + 4'h1;
                  noise_r <= noise_r | ~same;   // [R13]
                  zero_r  <= zero_r & ~maj;
                  if (bit_r <= db)
                  begin
                     if (ctrl_r.msb_first)
                        rxsh_r[db - bit_r] <= maj;
                     else
                        rxsh_r[bit_r - 4'h1] <= maj;
                  end
                  else
                     fe_r <= fe_now;
                  if (done)
                     rst_r <= S_HUNT;
               end
            end
            default: rst_r <= S_HUNT;
         endcase
      end

   // ----------------------------------------
   // Wakeup, idle and address filter
   // ----------------------------------------
   logic [10:0] idle_cnt_r;
   logic [10:0] idle_thr;
   logic        idle_ev;
   logic        idle_arm_r;
   logic        pass_r;
   logic        mark_ev;
   logic        mark;
   logic        hit;
   logic        filt_on;
   logic        keep;
   logic        deliver;

   assign idle_thr = 11'(cbits_f(ctrl_r)) * {4'h0, nseg};
   assign idle_ev  = ctrl_r.rx_on & stk & s & (idle_cnt_r == idle_thr - 11'h001);
   assign mark     = ctrl_r.msb_first ? rxsh_r[0] : rxsh_r[db - 4'h1];
   assign mark_ev  = stk & (rst_r == S_FRAME) & decide & (bit_r == db) & maj;
   assign sleep_clr = ctrl_r.rx_sleep
                    & (ctrl_r.wake_addr_mark ? mark_ev : idle_ev);  // [R18] [R21]
   assign filt_on  = ctrl_r.addr_compare_1_on | ctrl_r.addr_compare_2_on;
   assign hit      = (ctrl_r.addr_compare_1_on & (rxsh_r[7:0] == match_r[7:0]))
                   | (ctrl_r.addr_compare_2_on & (rxsh_r[7:0] == match_r[15:8]));
   assign keep     = ~filt_on | (mark ? hit : pass_r);               // [R22]
   assign deliver  = done & keep & ~ctrl_r.rx_sleep;                 // [R17]

   // Idle sample counter
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         idle_cnt_r <= 11'h000;
      else if (!ctrl_r.rx_on || (ctrl_r.idle_type_select && rst_r != S_HUNT))
         idle_cnt_r <= 11'h000;                 // [R20]
      else if (stk)
      begin
         if (!s)
            idle_cnt_r <= 11'h000;
         else if (idle_cnt_r < idle_thr)
            idle_cnt_r <= idle_cnt_r + 11'h001;
      end

   // Address pass state
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pass_r <= 1'b0;
      else if (done && mark && filt_on)
         pass_r <= hit;                         // [R22]

   // Status flags: hardware set wins over software clear
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         st_r       <= 6'h00;
         rxbuf_r    <= 10'h000;
         idle_arm_r <= 1'b0;
      end
      else
      begin
         st_r.tx_buffer_empty <= tx_free & ~brk_q_r & ~idle_q_r;
         if (wr_en && paddr == `OFS_STATUS)
         begin
            if (pwdata[1])
               st_r.overrun_flag <= 1'b0;
            if (pwdata[2])
               st_r.noise_flag <= 1'b0;
            if (pwdata[3])
               st_r.framing_error_flag <= 1'b0;
            if (pwdata[4])
               st_r.idle_flag <= 1'b0;
         end
         if (rd_data)
            st_r.rx_buffer_full <= 1'b0;
         if (deliver && st_r.rx_buffer_full)
            st_r.overrun_flag <= 1'b1;          // [R9]
         else if (deliver)
         begin
            st_r.rx_buffer_full     <= 1'b1;    // [R9]
            st_r.noise_flag         <= noise_r | ~same;  // [R13]
            st_r.framing_error_flag <= fe_now;
            rxbuf_r                 <= rxsh_r;
            idle_arm_r              <= 1'b1;    // [R24]
         end
         if (idle_ev && idle_arm_r
             && (!ctrl_r.rx_sleep || ctrl_r.sleep_idle_flag_allow))
         begin
            st_r.idle_flag <= 1'b1;             // [R19]
            idle_arm_r     <= 1'b0;             // [R24]
         end
      end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_brk_queue: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      bs_prev_r && !ctrl_r.break_send |=> brk_q_r)
      else $error("break not queued");
   a_brk_length: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      tx_tick && tx_free && brk_q_r |=> txbrk_r && txcnt_r == $past(brk_len))
      else $error("break length wrong");
   a_brk_low: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      txbrk_r && txcnt_r != 5'h00 |=> !tx_out)
      else $error("break not low");
   a_tx_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      txcnt_r != 5'h00 |=> tx_oe)
      else $error("pin released mid character");
   a_start_seek: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      ctrl_r.rx_on && stk && rst_r == S_HUNT && fedge |=> rst_r == S_START && seg_r == 7'h01)
      else $error("edge not taken");
   a_rx_off: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      !ctrl_r.rx_on |=> rst_r == S_HUNT)
      else $error("receiver ran while off");
   a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      deliver && st_r.rx_buffer_full |=> st_r.overrun_flag && rxbuf_r == $past(rxbuf_r))
      else $error("overrun handling wrong");
   a_sleep_block: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      done && ctrl_r.rx_sleep |=> !$rose(st_r.rx_buffer_full))
      else $error("flag set while asleep");
   a_idle_rearm: assert property (@(posedge pclk) disable iff (!presetn) // [R24]
      $rose(st_r.idle_flag) |-> $past(idle_arm_r))
      else $error("idle set without new character");
endmodule

// File: hw/uart_brk_map.svh
// Purpose: Register offsets, reset values and timing counts
// Assumes: APB, one aligned 32-bit word per register
// Notes:   Included by its bare name
`ifndef UART_BRK_MAP_SVH
`define UART_BRK_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL    8'h00
`define OFS_BAUD    8'h04
`define OFS_STATUS  8'h08
`define OFS_DATA    8'h0C
`define OFS_MATCH   8'h10
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL    22'h1E0000
`define RST_BAUD    13'h0004
// ----------------------------------------
// Frame lengths in bit times
// ----------------------------------------
`define BASE_BITS   4'hA
`define LONG_EXTRA  5'h03
`define BASE_DBITS  4'h8
`endif

// File: hw/uart_brk_pkg.sv
// Purpose: Types shared by the serial port block
// Assumes: Map header holds register offsets, reset values and frame lengths
// Notes:   Control word layout is the packed order below
package uart_brk_pkg;
   typedef struct packed {
      logic [4:0] osr_m1;      // Oversampling ratio minus one
      logic       addr_compare_2_on;
      logic       addr_compare_1_on;
      logic       msb_first;
      logic       long_break_select;
      logic       two_stop_select;
      logic       ten_bit_select;
      logic       nine_bit_select;
      logic       edge_realign_off;
      logic       dual_edge_sample;
      logic       rx_polarity_flip;
      logic       sleep_idle_flag_allow;
      logic       idle_type_select;
      logic       wake_addr_mark;
      logic       rx_sleep;
      logic       break_send;
      logic       rx_on;
      logic       tx_on;
   } ctrl_type;
   typedef struct packed {
      logic tx_buffer_empty;
      logic idle_flag;
      logic framing_error_flag;
      logic noise_flag;
      logic overrun_flag;
      logic rx_buffer_full;
   } stat_type;
   typedef enum logic [1:0] {
      S_HUNT  = 2'b00,
      S_START = 2'b01,
      S_FRAME = 2'b10
   } rx_state_type;
endpackage
